// ==== rtl/huq_pkg.sv ====
// Shared constants, register map and carrier types of the upstream message queue
package huq_pkg;

  // Data widths and storage depth
  localparam int RX_W = 8;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W = 5;
  localparam int CNT_W = 6;
  localparam int ADR_W = 8;
  localparam int EV_W = 6;
  localparam int SYNC_W = RX_W + 5;

  // Register byte offsets
  localparam logic [ADR_W-1:0] ADR_BUF = 8'h00;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h04;
  localparam logic [ADR_W-1:0] ADR_ISTS = 8'h08;
  localparam logic [ADR_W-1:0] ADR_ICLR = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_IEN = 8'h10;

  // Status and control word fields
  localparam int STS_LVL = 0;
  localparam int STS_RDY = 4;
  localparam int STS_ERR = 5;
  localparam int STS_WSEL = 6;
  localparam int STS_CNT = 8;
  localparam int CTRL_ERR_CLR = 0;

  // Event bits of status, clear and enable registers
  localparam int EV_LVL = 0;
  localparam int EV_RDY = 4;
  localparam int EV_ERR = 5;

  // Indicator bits of the final character
  localparam int FIN_CHG_BIT = 2;
  localparam int FIN_KEY_BIT = 4;

  // Fill thresholds in words
  localparam logic [CNT_W-1:0] LVL_Q1 = 6'h08;
  localparam logic [CNT_W-1:0] LVL_HALF = 6'h10;
  localparam logic [CNT_W-1:0] LVL_Q3 = 6'h18;
  localparam logic [CNT_W-1:0] LVL_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_STEP = 6'h02;
  localparam logic [CNT_W-1:0] CNT_ROOM = 6'h1e;

  // Ready interrupt hold-off, least time, rounded up
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLDOFF_NS = 1000000;
  localparam int unsigned HOLDOFF_CYC_DEF = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 17;

  typedef enum logic [2:0] {
    MS_IDLE, MS_ADDR, MS_CHECK, MS_STAT, MS_FINAL, MS_PUSH2
  } huq_msg_st_t;

  // Receiver side signals, all from outside the clock domain
  typedef struct packed {
    logic [RX_W-1:0] data;
    logic char_stb;
    logic msg_stb;
    logic overrun;
    logic framing;
    logic parity;
  } huq_rx_t;

  typedef struct packed {
    logic en;
    logic [WORD_W-1:0] word;
  } huq_wr_t;

  typedef struct packed {
    huq_msg_st_t msg;
    logic [RX_W-1:0] addr_b;
    logic [RX_W-1:0] stat_b;
    logic [RX_W-1:0] fin_b;
    logic msg_err;
    logic char_p;
    logic msg_p;
    logic [CNT_W-1:0] fill_cnt;
    logic [3:0] lvl_p;
    logic wsel;
    logic err_flag;
    logic [EV_W-1:0] ev_sts;
    logic [EV_W-1:0] ev_en;
    logic [HOLD_W-1:0] holdoff;
    huq_wr_t wr;
    logic pop;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } huq_state_t;

  localparam huq_state_t ST_RST = '0;

endpackage : huq_pkg

// ==== rtl/huq_sync3.sv ====
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module huq_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import huq_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } huq_sync_st_t;

  huq_sync_st_t s_q, s_d;

  // Stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    s_d = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.o = s_q.s3;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.o;

endmodule : huq_sync3

// ==== rtl/huq_fifo.sv ====
// Word store of the upstream queue; a message leaves as a pair of words
`timescale 1ns/1ps
module huq_fifo (
  input wire logic mclk,
  input wire logic resetn,
  input huq_pkg::huq_wr_t wr_i,
  input wire logic pop2_i,
  output logic [huq_pkg::WORD_W-1:0] head0_o,
  output logic [huq_pkg::WORD_W-1:0] head1_o
);
  import huq_pkg::*;

  typedef struct packed {
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
  } huq_ptr_t;

  huq_ptr_t s_q, s_d;
  logic [WORD_W-1:0] mem [FIFO_DEPTH];

  // Room is checked by the caller, so the pointers never pass each other
  always_comb begin
    s_d = s_q;
    if (wr_i.en) begin
      s_d.wp = PTR_W'(s_q.wp + 1'b1);
    end
    if (pop2_i) begin
      s_d.rp = PTR_W'(s_q.rp + 2'd2);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset; only counted words are ever read
  always_ff @(posedge mclk) begin
    if (wr_i.en) begin
      mem[s_q.wp] <= wr_i.word;
    end
  end

  assign head0_o = mem[s_q.rp];
  assign head1_o = mem[PTR_W'(s_q.rp + 1'b1)];

endmodule : huq_fifo

// ==== rtl/huq_upstream_queue.sv ====
// Upstream message queue: framing, filtering, word queue, host registers, interrupt
//
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Functional notes
// - Take 8-bit received characters with character and message sync strobes
// - Queue kept messages; host reads address word then status word from one register
// - Word select bit is zero at rest, one after first word, zero after second
// - Status word shows quarter, half, three-quarter and full levels
// - A level indicator becoming active requests an interrupt when enabled
// - Ready flag is high while the queue holds at least one word
// - Ready has its own enable; ready interrupt only while it is set
// - Check, overrun, framing and parity errors merge into one flag with enable
// - Discard the message when neither keystroke nor change bit is set
// - When either bit is set, write both message words into the queue
// - After a ready interrupt, block another ready interrupt for one millisecond
// - Ready and level indicators come from one upstream level counter
// - Level counter follows words written in and read out
module huq_upstream_queue #(
  parameter int unsigned HOLDOFF_CYC = huq_pkg::HOLDOFF_CYC_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [huq_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input huq_pkg::huq_rx_t rx_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);
  import huq_pkg::*;

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLDOFF_CYC);

  huq_state_t s_q, s_d;
  huq_rx_t rx_s;
  logic [WORD_W-1:0] head0, head1;
  logic req, rdy, char_edge, msg_edge, in_msg, line_err, chk_bad, q_ovf;
  logic err_new, err_clr, pop_now, rdy_irq_now, fin_keep;
  logic [3:0] lvl;
  logic [EV_W-1:0] ev_set, ev_clr;
  logic [31:0] sts;

  // Receiver pins come from another domain
  huq_sync3 #(
    .W(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d_i(rx_i),
    .q_o(rx_s)
  );

  huq_fifo u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .wr_i(s_q.wr),
    .pop2_i(s_q.pop),
    .head0_o(head0),
    .head1_o(head1)
  );

  // Whole next-state: framer, level counter, bus slave, events
  always_comb begin
    s_d = s_q;
    s_d.wr = '0;
    s_d.ack = 1'b0;
    s_d.dat = '0;
    ev_set = '0;
    ev_clr = '0;
    chk_bad = 1'b0;
    q_ovf = 1'b0;
    err_clr = 1'b0;
    pop_now = 1'b0;
    fin_keep = 1'b0;
    req = wb_cyc_i & wb_stb_i & ~s_q.ack;
    char_edge = rx_s.char_stb & ~s_q.char_p;
    msg_edge = rx_s.msg_stb & ~s_q.msg_p;
    s_d.char_p = rx_s.char_stb;
    s_d.msg_p = rx_s.msg_stb;
    in_msg = (s_q.msg != MS_IDLE) && (s_q.msg != MS_PUSH2);
    line_err = char_edge & in_msg & (rx_s.overrun | rx_s.framing | rx_s.parity);

    // Indicators all derive from the one counter
    rdy = s_q.fill_cnt != '0;
    lvl[0] = s_q.fill_cnt >= LVL_Q1;
    lvl[1] = s_q.fill_cnt >= LVL_HALF;
    lvl[2] = s_q.fill_cnt >= LVL_Q3;
    lvl[3] = s_q.fill_cnt == LVL_FULL;
    sts = '0;
    sts[STS_LVL +: 4] = lvl;
    sts[STS_RDY] = rdy;
    sts[STS_ERR] = s_q.err_flag;
    sts[STS_WSEL] = s_q.wsel;
    sts[STS_CNT +: CNT_W] = s_q.fill_cnt;

    // Message framer: address, check, new status, final character
    case (s_q.msg)
      MS_ADDR: begin
        if (char_edge) begin
          s_d.addr_b = rx_s.data;
          s_d.msg = MS_CHECK;
        end
      end
      MS_CHECK: begin
        if (char_edge) begin
          chk_bad = rx_s.data != s_q.addr_b;
          s_d.msg = MS_STAT;
        end
      end
      MS_STAT: begin
        if (char_edge) begin
          s_d.stat_b = rx_s.data;
          s_d.msg = MS_FINAL;
        end
      end
      MS_FINAL: begin
        if (char_edge) begin
          s_d.fin_b = rx_s.data;
          s_d.msg = MS_IDLE;
          fin_keep = rx_s.data[FIN_KEY_BIT] | rx_s.data[FIN_CHG_BIT];
          // A message with a damaged character is never queued
          if (fin_keep && !line_err && !s_q.msg_err) begin
            if (s_q.fill_cnt > CNT_ROOM) begin
              q_ovf = 1'b1;
            end else begin
              s_d.wr.en = 1'b1;
              s_d.wr.word = {8'h00, s_q.addr_b};
              s_d.msg = MS_PUSH2;
            end
          end
        end
      end
      MS_PUSH2: begin
        s_d.wr.en = 1'b1;
        s_d.wr.word = {s_q.stat_b, s_q.fin_b};
        s_d.msg = MS_IDLE;
      end
      default: begin
        s_d.msg = MS_IDLE;
      end
    endcase
    s_d.msg_err = s_q.msg_err | line_err | chk_bad;
    // A new message sync restarts framing; a pending second write still goes out
    if (msg_edge) begin
      s_d.msg = MS_ADDR;
      s_d.msg_err = 1'b0;
    end
    err_new = line_err | chk_bad | q_ovf;

    // Wishbone slave, one wait state, unmapped reads return zero
    if (req) begin
      s_d.ack = 1'b1;
      case (wb_adr_i)
        ADR_BUF: begin
          if (!wb_we_i && rdy) begin
            s_d.dat = 32'(s_q.wsel ? head1 : head0);
            s_d.wsel = ~s_q.wsel;
            pop_now = s_q.wsel;
          end
        end
        ADR_CTRL: begin
          if (wb_we_i) begin
            err_clr = wb_sel_i[0] & wb_dat_i[CTRL_ERR_CLR];
          end else begin
            s_d.dat = sts;
          end
        end
        ADR_ISTS: begin
          if (!wb_we_i) begin
            s_d.dat = 32'(s_q.ev_sts);
          end
        end
        ADR_ICLR: begin
          if (wb_we_i && wb_sel_i[0]) begin
            ev_clr = wb_dat_i[EV_W-1:0];
          end
        end
        ADR_IEN: begin
          if (!wb_we_i) begin
            s_d.dat = 32'(s_q.ev_en);
          end else if (wb_sel_i[0]) begin
            s_d.ev_en = wb_dat_i[EV_W-1:0];
          end
        end
        default: begin
          s_d.dat = '0;
        end
      endcase
    end
    s_d.pop = pop_now;

    // Counter moves by a message pair in the PUSH2 cycle, as the first word lands, or on removal
    s_d.fill_cnt = s_q.fill_cnt + ((s_q.msg == MS_PUSH2) ? CNT_STEP : '0)
                   - (pop_now ? CNT_STEP : '0);

    // Sticky events; a set in the clearing cycle wins
    s_d.lvl_p = lvl;
    ev_set[EV_LVL +: 4] = lvl & ~s_q.lvl_p;
    ev_set[EV_RDY] = rdy && (s_q.holdoff == '0) && !s_q.ev_sts[EV_RDY];
    ev_set[EV_ERR] = err_new;
    s_d.err_flag = (s_q.err_flag & ~err_clr) | err_new;
    s_d.ev_sts = (s_q.ev_sts & ~ev_clr) | ev_set;

    // Hold-off starts when a ready request actually reaches the host
    rdy_irq_now = s_d.ev_sts[EV_RDY] & s_d.ev_en[EV_RDY];
    if (rdy_irq_now && !(s_q.ev_sts[EV_RDY] & s_q.ev_en[EV_RDY])) begin
      s_d.holdoff = HOLD_LOAD;
    end else if (s_q.holdoff != '0) begin
      s_d.holdoff = s_q.holdoff - 1'b1;
    end
    s_d.irq = |(s_d.ev_sts & s_d.ev_en);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign wb_dat_o = s_q.dat;
  assign wb_ack_o = s_q.ack;
  assign irq = s_q.irq;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Address character lands in the address holder
  property p_addr_capture;
    (char_edge && s_q.msg == MS_ADDR && !msg_edge) |=> (s_q.addr_b == $past(rx_s.data));
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address char not captured");

  // Ready and the full level read back as the counter stands
  property p_status_read;
    (req && !wb_we_i && wb_adr_i == ADR_CTRL) |=>
      (wb_dat_o[STS_RDY] == ($past(s_q.fill_cnt) != '0))
      && (wb_dat_o[STS_LVL + 3] == ($past(s_q.fill_cnt) == LVL_FULL));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status flags wrong");

  property p_wsel_first;
    (req && !wb_we_i && wb_adr_i == ADR_BUF && rdy && !s_q.wsel) |=> s_q.wsel && wb_ack_o;
  endproperty
  a_wsel_first: assert property (p_wsel_first) else $error("word select not set");

  property p_pair_removed;
    (req && !wb_we_i && wb_adr_i == ADR_BUF && rdy && s_q.wsel && s_q.msg != MS_PUSH2)
      |=> (!s_q.wsel && s_q.fill_cnt == $past(s_q.fill_cnt) - CNT_STEP) ##1 !s_q.pop;
  endproperty
  a_pair_removed: assert property (p_pair_removed) else $error("pair not removed");

  property p_pair_stored;
    (s_q.msg == MS_PUSH2 && !pop_now) |-> s_d.wr.en ##1 (s_q.fill_cnt == $past(s_q.fill_cnt) + CNT_STEP);
  endproperty
  a_pair_stored: assert property (p_pair_stored) else $error("pair not stored");

  property p_discard;
    (s_q.msg == MS_FINAL && char_edge && !fin_keep && !msg_edge) |=>
      (!s_q.wr.en && s_q.msg == MS_IDLE)[*2];
  endproperty
  a_discard: assert property (p_discard) else $error("unflagged message kept");

  property p_level_irq;
    (lvl[0] && !s_q.lvl_p[0] && s_q.ev_en[EV_LVL] && !req) |=> irq && s_q.ev_sts[EV_LVL];
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level interrupt missing");

  property p_holdoff_load;
    $rose(s_q.ev_sts[EV_RDY] & s_q.ev_en[EV_RDY]) |-> (s_q.holdoff == HOLD_LOAD) && irq;
  endproperty
  a_holdoff_load: assert property (p_holdoff_load) else $error("holdoff not started");

  property p_no_reissue;
    (s_q.holdoff != '0 && !s_q.ev_sts[EV_RDY]) |=> !s_q.ev_sts[EV_RDY];
  endproperty
  a_no_reissue: assert property (p_no_reissue) else $error("ready reissued in holdoff");

  property p_ready_gate;
    (!s_q.ev_en[EV_RDY] && s_q.ev_sts[EV_RDY] && (s_q.ev_sts & s_q.ev_en) == '0 && !req
      && (ev_set & s_q.ev_en) == '0) |=> !irq;
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("ready irq while disabled");

  property p_err_hold;
    (s_q.err_flag && !(req && wb_we_i && wb_adr_i == ADR_CTRL)) |=> s_q.err_flag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  // Any damaged character inside a message raises the merged flag and its event
  property p_line_err;
    (char_edge && in_msg && (rx_s.overrun || rx_s.framing || rx_s.parity)) |=>
      s_q.err_flag && s_q.ev_sts[EV_ERR];
  endproperty
  a_line_err: assert property (p_line_err) else $error("line error not flagged");

  // Counter moves by whole pairs and never runs past the store
  property p_count_bound;
    (s_q.fill_cnt <= LVL_FULL) |=> (s_q.fill_cnt <= LVL_FULL) && !s_q.fill_cnt[0];
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("counter out of range");

endmodule : huq_upstream_queue

// ==== bench/huq_rx_model.sv ====
// Behavioural model of the shared receiver that delivers upstream characters
`timescale 1ns/1ps
module huq_rx_model (
  input wire logic mclk,
  output huq_pkg::huq_rx_t rx_o
);
  import huq_pkg::*;

  // Quiet link at time zero, so the filter starts from idle
  initial rx_o = '0;

  // One character: data settles, strobe high, strobe low, then data released
  task automatic put_char(input logic [RX_W-1:0] d, input logic [2:0] e);
    rx_o.data <= d;
    {rx_o.overrun, rx_o.framing, rx_o.parity} <= e;
    repeat (4) @(posedge mclk);
    rx_o.char_stb <= 1'b1;
    repeat (4) @(posedge mclk);
    rx_o.char_stb <= 1'b0;
    @(posedge mclk);
    rx_o.data <= ~d;  // Released lines must not show a stale byte
    {rx_o.overrun, rx_o.framing, rx_o.parity} <= 3'b000;
    repeat (4) @(posedge mclk);
  endtask : put_char

  // Message sync, then address, check, new status and final characters
  task automatic send_msg(input logic [7:0] a, c, s, f, input logic [2:0] e);
    @(posedge mclk);
    rx_o.msg_stb <= 1'b1;
    repeat (4) @(posedge mclk);
    rx_o.msg_stb <= 1'b0;
    repeat (4) @(posedge mclk);
    put_char(a, 3'b000);
    put_char(c, 3'b000);
    put_char(s, e);
    put_char(f, 3'b000);
  endtask : send_msg
endmodule : huq_rx_model

// ==== bench/huq_upstream_queue_bench.sv ====
// Self-checking bench of the upstream message queue
`timescale 1ns/1ps
module huq_upstream_queue_bench;
  import huq_pkg::*;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} huq_note_t;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0] wb_sel = '0;
  logic [31:0] wb_wdat = '0;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic irq;
  huq_rx_t rx;
  huq_note_t notes[$];
  huq_note_t cur;
  logic [7:0] a_q[$], s_q[$], f_q[$];
  logic [7:0] fins[5] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'heb};
  int err_count = 0;
  int compares = 0;

  always #5 mclk = ~mclk;

  huq_upstream_queue #(.HOLDOFF_CYC(50)) dut_u (
    .mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .rx_i(rx), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(irq));

  huq_rx_model rx_u (.mclk(mclk), .rx_o(rx));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // Classic single cycle; held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'h1;
    wb_wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) begin
      check("wb_ack", 32'h0, 32'h1);
      report_and_stop();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb

  // Note the expected read data, then run the read
  task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    notes.push_back('{$sformatf("read %h", a), e & m, m});
    wb(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [31:0] ctrl_exp(input int c, input logic ws, input logic er);
    ctrl_exp = {18'h0, 6'(c), 1'b0, ws, er, c != 0, c == 32, c >= 24, c >= 16, c >= 8};
  endfunction : ctrl_exp

  // Kind 0 clean, 1 check mismatch, 2 overrun, 3 framing, 4 parity
  task automatic send(input int kind, input logic [7:0] f);
    logic [7:0] a, s;
    logic keep;
    a = 8'($urandom);
    s = 8'($urandom);
    keep = kind == 0 && (f[FIN_CHG_BIT] || f[FIN_KEY_BIT]) && a_q.size() < 16;
    rx_u.send_msg(a, (kind == 1) ? ~a : a, s, f, (kind > 1) ? 3'(1 << (4 - kind)) : 3'b000);
    if (keep) begin
      a_q.push_back(a);
      s_q.push_back(s);
      f_q.push_back(f);
    end
    repeat (6) @(posedge mclk);
  endtask : send

  // Read one message back as its two words
  task automatic drain();
    int c;
    c = 2 * a_q.size();
    rd(ADR_BUF, {24'h0, a_q.pop_front()});
    rd(ADR_CTRL, ctrl_exp(c, 1'b1, 1'b0));
    rd(ADR_BUF, {16'h0, s_q.pop_front(), f_q.pop_front()});
    rd(ADR_CTRL, ctrl_exp(c - 2, 1'b0, 1'b0));
  endtask : drain

  // Scoreboard: each acknowledged read meets the oldest note
  always @(posedge mclk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      check(cur.name, wb_rdat & cur.mask, cur.exp);
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    void'($urandom(47));
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rd(ADR_CTRL, 32'h0);
    rd(ADR_ISTS, 32'h0);
    rd(ADR_IEN, 32'h0);
    rd(ADR_BUF, 32'h0);
    rd(8'h14, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wb(1'b1, ADR_IEN, 32'h3f);
    wb(1'b1, ADR_BUF, 32'hff);  // Read-only place, write has no effect
    rd(ADR_IEN, 32'h3f);
    // Ready event cleared while the hold-off still runs
    send(0, 8'h10);
    wb(1'b1, ADR_ICLR, 32'h10);
    rd(ADR_ISTS, 32'h0, 32'h10);
    rd(ADR_CTRL, ctrl_exp(2, 1'b0, 1'b0));
    repeat (60) @(posedge mclk);
    rd(ADR_ISTS, 32'h10, 32'h10);
    check("irq", {31'h0, irq}, 32'h1);
    drain();
    wb(1'b1, ADR_ICLR, 32'h3f);
    rd(ADR_ISTS, 32'h0);
    // Change and keystroke indicator combinations
    foreach (fins[i]) begin
      send(0, fins[i]);
      if (a_q.size() > 0) drain();
      else rd(ADR_CTRL, 32'h0);
    end
    wb(1'b1, ADR_ICLR, 32'h3f);
    // Check, overrun, framing and parity errors each set the one sticky flag
    for (int k = 1; k <= 4; k++) begin
      send(k, 8'h14);
      rd(ADR_CTRL, ctrl_exp(0, 1'b0, 1'b1));
      rd(ADR_ISTS, 32'h20, 32'h20);
      rd(ADR_CTRL, ctrl_exp(0, 1'b0, 1'b1));
      wb(1'b1, ADR_CTRL, 32'h1);
      wb(1'b1, ADR_ICLR, 32'h20);
      rd(ADR_CTRL, 32'h0);
    end
    // Fill to the top, overflow once, then drain with the levels falling
    repeat (16) send(0, 8'h14);
    rd(ADR_CTRL, ctrl_exp(32, 1'b0, 1'b0));
    rd(ADR_ISTS, 32'h0f, 32'h0f);
    send(0, 8'h10);
    rd(ADR_CTRL, ctrl_exp(32, 1'b0, 1'b1));
    wb(1'b1, ADR_CTRL, 32'h1);
    while (a_q.size() > 0) drain();
    check("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, ADR_IEN, 32'h0);
    repeat (2) @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h0);
    wb(1'b1, ADR_IEN, 32'h3f);
    repeat (2) @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, ADR_ICLR, 32'h3f);
    repeat (2) @(posedge mclk);
    check("irq", {31'h0, irq}, 32'h0);
    report_and_stop();
  end
endmodule : huq_upstream_queue_bench
